/* File: hw/led_gpio_pin_function_mux.sv */
`timescale 1ns/100ps
module led_gpio_pin_function_mux
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // mode and configuration
    input mac_mode_e mac_mode,
    input wire logic led_mode,
    input pin_cfg_s speed_cfg,
    input pin_cfg_s col_cfg,
    input pin_cfg_s rxd3_cfg,
    input sig_mode_e sig_force,
    // link status
    input wire logic link_speed,
    input wire logic link_full_duplex,
    input wire logic link_activity,
    input sig_mode_e sig_detected,
    // data path from the mac side of the phy
    input wire logic collision,
    input wire logic rx_data_bit3,
    // speed_indicator_pin / general_purpose_pin_one
    input wire logic speed_indicator_pin_i,
    output logic speed_indicator_pin_o,
    output logic speed_indicator_pin_oe,
    // collision pin / general_purpose_pin_two
    input wire logic general_purpose_pin_two_i,
    output logic general_purpose_pin_two_o,
    output logic general_purpose_pin_two_oe,
    // receive_data_bit_three / general_purpose_pin_three
    input wire logic general_purpose_pin_three_i,
    output logic receive_data_bit_three_o,
    output logic receive_data_bit_three_oe,
    // status
    output logic [2:0] gpio_in_r,
    output sig_mode_e sig_active_r
);

    // --------------------------------------------------------------
    // shared drive decode
    // --------------------------------------------------------------
    function automatic pin_drv_s gpio_drive(input pin_cfg_s cfg);
        pin_drv_s d;
        d.o = cfg.gpio_out & cfg.gpio_oe;
        d.oe = cfg.gpio_oe;
        return d;
    endfunction : gpio_drive

    pin_drv_s spd_nxt;
    pin_drv_s col_nxt;
    pin_drv_s rxd_nxt;
    pin_drv_s spd_r;
    pin_drv_s col_r;
    pin_drv_s rxd_r;
    logic spd_sync_r;
    logic col_sync_r;
    logic rxd_sync_r;
    logic led_allowed_rxd;

    // --------------------------------------------------------------
    // speed pin
    // --------------------------------------------------------------
    always_comb
    begin
        spd_nxt = PIN_DRV_RESET;
        unique case (speed_cfg.fn)
            FN_GPIO:
                spd_nxt = gpio_drive(speed_cfg);
            FN_LED:
                spd_nxt = '{link_speed == SPEED_100, 1'h1};
            default:
                if (led_mode == LED_MODE_TWO)
                    spd_nxt = '{link_speed == SPEED_100, 1'h1};
                else
                    spd_nxt = PIN_DRV_RESET;
        endcase
    end

    // --------------------------------------------------------------
    // collision pin
    // --------------------------------------------------------------
    always_comb
    begin
        col_nxt = '{collision, 1'h1};
        unique case (col_cfg.fn)
            FN_GPIO:
                col_nxt = gpio_drive(col_cfg);
            FN_LED:
                if (mac_mode == MAC_MII)
                    col_nxt = '{link_full_duplex, 1'h1};
                else
                    col_nxt = '{link_activity, 1'h1};
            default:
                col_nxt = '{collision, 1'h1};
        endcase
    end

    // --------------------------------------------------------------
    // receive data bit three
    // --------------------------------------------------------------
    assign led_allowed_rxd = (mac_mode == MAC_RMII);

    always_comb
    begin
        rxd_nxt = '{rx_data_bit3, 1'h1};
        unique case (rxd3_cfg.fn)
            FN_GPIO:
                rxd_nxt = gpio_drive(rxd3_cfg);
            FN_LED:
                if (led_allowed_rxd)
                    rxd_nxt = '{link_activity, 1'h1};
                else
                    rxd_nxt = '{rx_data_bit3, 1'h1};
            default:
                rxd_nxt = '{rx_data_bit3, 1'h1};
        endcase
    end

    pin_drive_reg u_spd
    (
        .clock(clock),
        .rst(rst),
        .drv_nxt(spd_nxt),
        .drv_r(spd_r),
        .pin_i(speed_indicator_pin_i),
        .pin_sync_r(spd_sync_r)
    );

    pin_drive_reg u_col
    (
        .clock(clock),
        .rst(rst),
        .drv_nxt(col_nxt),
        .drv_r(col_r),
        .pin_i(general_purpose_pin_two_i),
        .pin_sync_r(col_sync_r)
    );

    pin_drive_reg u_rxd
    (
        .clock(clock),
        .rst(rst),
        .drv_nxt(rxd_nxt),
        .drv_r(rxd_r),
        .pin_i(general_purpose_pin_three_i),
        .pin_sync_r(rxd_sync_r)
    );

    assign speed_indicator_pin_o = spd_r.o;
    assign speed_indicator_pin_oe = spd_r.oe;
    assign general_purpose_pin_two_o = col_r.o;
    assign general_purpose_pin_two_oe = col_r.oe;
    assign receive_data_bit_three_o = rxd_r.o;
    assign receive_data_bit_three_oe = rxd_r.oe;

    // --------------------------------------------------------------
    // status: gpio inputs and active signalling
    // --------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            gpio_in_r <= 3'h0;
        else
            gpio_in_r <= {rxd_sync_r, col_sync_r, spd_sync_r};
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            sig_active_r <= SIG_AUTO;
        else if (sig_force != SIG_AUTO)
            sig_active_r <= sig_force;
        else
            sig_active_r <= sig_detected;
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // no attempt starts on the edge that releases reset
    sequence s_mode_one_idle;
        !rst && speed_cfg.fn != FN_GPIO && speed_cfg.fn != FN_LED
            && led_mode == LED_MODE_ONE;
    endsequence

    sequence s_mode_two_led;
        !rst && speed_cfg.fn != FN_GPIO && speed_cfg.fn != FN_LED
            && led_mode == LED_MODE_TWO;
    endsequence

    chk_speed_tristate: assert property (
        @(posedge clock) disable iff (rst)
        s_mode_one_idle |=> !speed_indicator_pin_oe)
        else $error("speed pin driven in led mode one");

    chk_speed_led_value: assert property (
        @(posedge clock) disable iff (rst)
        s_mode_two_led |=> speed_indicator_pin_oe
            && speed_indicator_pin_o == $past(link_speed))
        else $error("speed led does not follow link speed");

    chk_speed_gpio_out: assert property (
        @(posedge clock) disable iff (rst)
        !rst && speed_cfg.fn == FN_GPIO |=> speed_indicator_pin_oe
            == $past(speed_cfg.gpio_oe))
        else $error("speed pin gpio enable wrong");

    chk_col_duplex_led: assert property (
        @(posedge clock) disable iff (rst)
        !rst && col_cfg.fn == FN_LED && mac_mode == MAC_MII
            |=> general_purpose_pin_two_o == $past(link_full_duplex))
        else $error("collision pin duplex led wrong");

    chk_col_led_other: assert property (
        @(posedge clock) disable iff (rst)
        !rst && col_cfg.fn == FN_LED && mac_mode != MAC_MII
            |=> general_purpose_pin_two_o == $past(link_activity))
        else $error("collision pin led wrong");

    chk_col_gpio_out: assert property (
        @(posedge clock) disable iff (rst)
        !rst && col_cfg.fn == FN_GPIO && col_cfg.gpio_oe
            |=> general_purpose_pin_two_o == $past(col_cfg.gpio_out))
        else $error("collision pin gpio value wrong");

    chk_rxd_keeps_data: assert property (
        @(posedge clock) disable iff (rst)
        !rst && rxd3_cfg.fn != FN_GPIO && mac_mode != MAC_RMII
            |=> receive_data_bit_three_o == $past(rx_data_bit3))
        else $error("data bit three left its data role");

    chk_rxd_rmii_led: assert property (
        @(posedge clock) disable iff (rst)
        !rst && rxd3_cfg.fn == FN_LED && mac_mode == MAC_RMII
            |=> receive_data_bit_three_o == $past(link_activity))
        else $error("data bit three led wrong in rmii");

    chk_rxd_gpio_out: assert property (
        @(posedge clock) disable iff (rst)
        !rst && rxd3_cfg.fn == FN_GPIO |=> receive_data_bit_three_oe
            == $past(rxd3_cfg.gpio_oe))
        else $error("data bit three gpio enable wrong");

    chk_sig_forced: assert property (
        @(posedge clock) disable iff (rst)
        !rst && sig_force != SIG_AUTO |=> sig_active_r == $past(sig_force))
        else $error("forced signalling not applied");

    chk_gpio_priority: assert property (
        @(posedge clock) disable iff (rst)
        !rst && speed_cfg.fn == FN_GPIO && !speed_cfg.gpio_oe
            |=> !speed_indicator_pin_oe)
        else $error("led mode overrode gpio setting");

endmodule : led_gpio_pin_function_mux

/* File: hw/pin_drive_reg.sv */
`timescale 1ns/100ps
// registered driver for one pin, plus two-flop input synchroniser
module pin_drive_reg
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // drive request
    input pin_drv_s drv_nxt,
    output pin_drv_s drv_r,
    // pin input
    input wire logic pin_i,
    output logic pin_sync_r
);

    logic meta_r;

    always_ff @(posedge clock)
    begin
        if (rst)
            drv_r <= PIN_DRV_RESET;
        else
            drv_r <= drv_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_r <= 1'h0;
            pin_sync_r <= 1'h0;
        end
        else
        begin
            meta_r <= pin_i;
            pin_sync_r <= meta_r;
        end
    end

endmodule : pin_drive_reg

/* File: include/pin_mux_pkg.sv */
package pin_mux_pkg;

    // --------------------------------------------------------------
    // mac interface and led modes
    // --------------------------------------------------------------
    typedef enum logic [1:0]
    {
        MAC_MII = 2'h0,
        MAC_RMII = 2'h1,
        MAC_RGMII = 2'h2
    } mac_mode_e;

    typedef enum logic [1:0]
    {
        FN_DEFAULT = 2'h0,
        FN_LED = 2'h1,
        FN_GPIO = 2'h2
    } pin_fn_e;

    typedef enum logic [1:0]
    {
        SIG_AUTO = 2'h0,
        SIG_10TE = 2'h1,
        SIG_100TX = 2'h2,
        SIG_100FX = 2'h3
    } sig_mode_e;

    localparam logic LED_MODE_ONE = 1'h0;
    localparam logic LED_MODE_TWO = 1'h1;
    localparam logic SPEED_100 = 1'h1;

    // --------------------------------------------------------------
    // per-pin settings and drive
    // --------------------------------------------------------------
    typedef struct packed
    {
        pin_fn_e fn;
        logic gpio_out;
        logic gpio_oe;
    } pin_cfg_s;

    typedef struct packed
    {
        logic o;
        logic oe;
    } pin_drv_s;

    localparam pin_cfg_s PIN_CFG_RESET = '{FN_DEFAULT, 1'h0, 1'h0};
    localparam pin_drv_s PIN_DRV_RESET = '{1'h0, 1'h0};

endpackage : pin_mux_pkg

/* File: verification/board_pins.sv */
`timescale 1ns/100ps
// board side of the three shared pins
module board_pins
    import pin_mux_pkg::*;
(
    // drive from the phy
    input wire logic [2:0] phy_o,
    input wire logic [2:0] phy_oe,
    // board sources
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    // resolved pin levels
    output logic [2:0] level
);
    always_comb
    begin
        level[0] = phy_oe[0] ? phy_o[0] : (ext_en[0] & ext_val[0]);
        level[2] = phy_oe[2] ? phy_o[2] : (ext_en[2] & ext_val[2]);
        // no pull on the collision pin: floats to inverse of phy_o[1], which is low while undriven
        level[1] = phy_oe[1] ? phy_o[1] : (ext_en[1] ? ext_val[1] : ~phy_o[1]);
    end
endmodule : board_pins

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) \
    begin n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end end
module tb_top;
    import pin_mux_pkg::*;
    logic clock = 1'h0;
    logic rst = 1'h1;
    mac_mode_e mac_mode = MAC_MII;
    logic led_mode = 1'h0;
    pin_cfg_s speed_cfg = PIN_CFG_RESET;
    pin_cfg_s col_cfg = PIN_CFG_RESET;
    pin_cfg_s rxd3_cfg = PIN_CFG_RESET;
    sig_mode_e sig_force = SIG_AUTO;
    sig_mode_e sig_detected = SIG_AUTO;
    logic link_speed = 1'h0;
    logic link_full_duplex = 1'h0;
    logic link_activity = 1'h0;
    logic collision = 1'h0;
    logic rx_data_bit3 = 1'h0;
    logic [2:0] ext_en = 3'h0;
    logic [2:0] ext_val = 3'h0;
    logic [2:0] pin_o, pin_oe, level, gpio_in_r;
    sig_mode_e sig_active_r;
    logic [15:0] lfsr_r = 16'hE73A;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] r;

    initial forever #10 clock = ~clock;

    board_pins partner (.phy_o(pin_o), .phy_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .level(level));

    led_gpio_pin_function_mux DUT (.clock(clock), .rst(rst),
        .mac_mode(mac_mode), .led_mode(led_mode), .speed_cfg(speed_cfg),
        .col_cfg(col_cfg), .rxd3_cfg(rxd3_cfg), .sig_force(sig_force),
        .link_speed(link_speed), .link_full_duplex(link_full_duplex),
        .link_activity(link_activity), .sig_detected(sig_detected),
        .collision(collision), .rx_data_bit3(rx_data_bit3),
        .speed_indicator_pin_i(level[0]),
        .speed_indicator_pin_o(pin_o[0]), .speed_indicator_pin_oe(pin_oe[0]),
        .general_purpose_pin_two_i(level[1]),
        .general_purpose_pin_two_o(pin_o[1]),
        .general_purpose_pin_two_oe(pin_oe[1]),
        .general_purpose_pin_three_i(level[2]),
        .receive_data_bit_three_o(pin_o[2]),
        .receive_data_bit_three_oe(pin_oe[2]),
        .gpio_in_r(gpio_in_r), .sig_active_r(sig_active_r));

    // ----------------------------------------------------------
    // expectations
    // ----------------------------------------------------------
    function automatic pin_drv_s e_gpio(pin_cfg_s c);
        return '{c.gpio_out & c.gpio_oe, c.gpio_oe};
    endfunction : e_gpio

    function automatic pin_drv_s e_speed();
        if (speed_cfg.fn == FN_GPIO) return e_gpio(speed_cfg);
        if (speed_cfg.fn == FN_LED || led_mode == LED_MODE_TWO)
            return '{link_speed, 1'h1};
        return '{1'h0, 1'h0};
    endfunction : e_speed

    function automatic pin_drv_s e_col();
        if (col_cfg.fn == FN_GPIO) return e_gpio(col_cfg);
        if (col_cfg.fn == FN_LED)
            return '{mac_mode == MAC_MII ? link_full_duplex : link_activity,
                1'h1};
        return '{collision, 1'h1};
    endfunction : e_col

    function automatic pin_drv_s e_rxd3();
        if (rxd3_cfg.fn == FN_GPIO) return e_gpio(rxd3_cfg);
        if (rxd3_cfg.fn == FN_LED && mac_mode == MAC_RMII)
            return '{link_activity, 1'h1};
        return '{rx_data_bit3, 1'h1};
    endfunction : e_rxd3

    function automatic logic [2:0] e_levels();
        pin_drv_s d [3];
        logic [2:0] v;
        d[0] = e_speed();
        d[1] = e_col();
        d[2] = e_rxd3();
        for (int i = 0; i < 3; i++)
            v[i] = d[i].oe ? d[i].o : (ext_en[i] ? ext_val[i] : (i == 1));
        return v;
    endfunction : e_levels

    function automatic logic [15:0] lfsr_next(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    // ----------------------------------------------------------
    // stimulus and checks
    // ----------------------------------------------------------
    task automatic apply(logic [31:0] v);
        @(posedge clock);
        mac_mode <= mac_mode_e'(v[1:0]);
        led_mode <= v[2];
        speed_cfg <= pin_cfg_s'(v[6:3]);
        col_cfg <= pin_cfg_s'(v[10:7]);
        rxd3_cfg <= pin_cfg_s'(v[14:11]);
        sig_force <= sig_mode_e'(v[16:15]);
        {link_activity, link_full_duplex, link_speed} <= v[19:17];
        sig_detected <= sig_mode_e'(v[21:20]);
        {rx_data_bit3, collision} <= v[23:22];
        ext_en <= v[26:24];
        ext_val <= v[29:27];
        repeat (4) @(posedge clock);
        @(negedge clock);
        `CHK("speed", e_speed(), {pin_o[0], pin_oe[0]})
        `CHK("col", e_col(), {pin_o[1], pin_oe[1]})
        `CHK("rxd3", e_rxd3(), {pin_o[2], pin_oe[2]})
        `CHK("sig", sig_force == SIG_AUTO ? sig_detected : sig_force,
            sig_active_r)
        `CHK("gpio_in", e_levels(), gpio_in_r)
    endtask : apply

    task automatic next_rand();
        lfsr_r = lfsr_next(lfsr_r);
        r[15:0] = lfsr_r;
        lfsr_r = lfsr_next(lfsr_r);
        r[31:16] = lfsr_r;
    endtask : next_rand

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic check_reset();
        @(negedge clock);
        `CHK("reset_oe", 3'h0, pin_oe)
        `CHK("reset_o", 3'h0, pin_o)
        `CHK("reset_sig", SIG_AUTO, sig_active_r)
    endtask : check_reset

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        repeat (11) @(posedge clock);
        check_reset();
        @(posedge clock);
        rst <= 1'h0;
        // every mac mode, function code and led mode
        for (int m = 0; m < 4; m++)
            for (int f = 0; f < 4; f++)
                for (int l = 0; l < 2; l++)
                begin
                    next_rand();
                    r[2:0] = {l[0], m[1:0]};
                    r[6:5] = f[1:0];
                    r[10:9] = f[1:0];
                    r[14:13] = f[1:0];
                    r[16:15] = f[1:0];
                    apply(r);
                end
        @(posedge clock);
        rst <= 1'h1;
        repeat (2) @(posedge clock);
        check_reset();
        @(posedge clock);
        rst <= 1'h0;
        repeat (200)
        begin
            next_rand();
            apply(r);
        end
        complete_run();
    end
endmodule : tb_top
